// ==== inc/vcomb_pkg.sv ====
// Constants and carriers for the vertical pattern combiner
// Functional notes
// RL1: Group D fifth toggle, gated by enable
// RL2: Address 0x20 bit 13 enters alternation
// RL3: Map enable routes hold words to selects
// RL4: Four 18-bit select words, one per segment bit
// RL5: Select pair 00/01/10/11 picks A/B/C/D
// RL6: Even lines use even pair, odd lines odd
// RL7: Bits 12:0 hold, 17:13 continue positions
// RL8: Select function only while alternation enabled
// RL9: First group A count gives segment count
// RL10: Software keeps four group lengths equal
// RL11: Insert bits 0/1/2 replace one A repetition
// RL12: Each output follows its selected group
// RL13: Software defaults all outputs to group A
// RL14: Merge field 0x01 joins sixteen toggles
// RL15: Merged toggles use group A timing only
// RL16: Software may reuse choices for unused groups
// RL17: Final repetition uses its own length
// RL18: Software sets final length equal normal length
// RL19: Odd and even lines use separate counts
// RL20: Group A supports 3- and 4-line cycles
// RL21: Software sets blanking mode 2 for alternation
// RL22: Software writes equal odd and even selects
// RL23: Segments start at bit 0, one per step
// RL24: Enabled fifth toggle applies to all outputs
package vcomb_pkg;
  localparam int PW       = 13;
  localparam int DW       = 26;
  localparam int ADR_W    = 8;
  localparam int NOUT     = 24;
  localparam int NGRP     = 4;
  localparam int NTG      = 5;
  localparam int TG4      = 4;
  localparam int NSLT     = 17;
  localparam int NHOLD    = 4;
  localparam int NREG     = 23;
  localparam int NPW      = 16;
  localparam int PAT_AW   = 4;
  localparam int SEL_W    = 18;
  localparam int SEG_W    = 5;
  localparam int CHO_W    = 3;
  localparam int GSEL_PER = 12;
  localparam int SER_BITS = 34;
  localparam logic [5:0] SER_LEN = 6'h22;
  localparam logic [5:0] SER_ONE = 6'h01;
  localparam logic [ADR_W-1:0] A_SEQ  = 8'h00;
  localparam logic [ADR_W-1:0] A_GRP0 = 8'h01;
  localparam logic [ADR_W-1:0] A_GRPN = 8'h17;
  localparam logic [ADR_W-1:0] A_MODE = 8'h20;
  localparam logic [ADR_W-1:0] A_PAT0 = 8'h40;
  localparam logic [ADR_W-1:0] A_PATN = 8'h4F;
  localparam int F_SPC   = 0;
  localparam int F_HOLD  = 4;
  localparam int F_LINES = 8;
  localparam int F_MERGE = 10;
  localparam int F_FINAL = 16;
  localparam int F_FIFTH = 20;
  localparam int B_ALT   = 13;
  localparam int B_MAP   = 14;
  localparam int B_POL   = 13;
  localparam int F_HI    = 13;
  localparam int F_TOG5  = 3;
  localparam int I_START  = 0;
  localparam int I_LEN    = 1;
  localparam int I_REP    = 2;
  localparam int I_CHO    = 3;
  localparam int I_STRIDE = 4;
  localparam int I_AREP34 = 16;
  localparam int I_HOLD0  = 17;
  localparam int I_GSEL0  = 21;
  localparam logic [3:0] MERGE_ON = 4'h1;
  localparam logic [12:0] ONE13 = 13'h0001;
  localparam logic [1:0] G_A = 2'h0;
  localparam logic [1:0] G_B = 2'h1;
  localparam logic [1:0] G_C = 2'h2;
  localparam logic [1:0] G_D = 2'h3;
  localparam logic [1:0] PH_LAST2 = 2'h1;
  localparam logic [1:0] PH_LAST3 = 2'h2;
  localparam logic [1:0] PH_LAST4 = 2'h3;
  localparam logic [1:0] PH_STEP  = 2'h1;

  typedef logic [NSLT-1:0][PW-1:0] tog_pos_t;
  typedef logic [NSLT-1:0]         tog_en_t;
  typedef enum {GW_IDLE, GW_WAIT, GW_RUN} gw_state_t;

  typedef struct packed {
    logic          wr;
    logic [ADR_W-1:0] addr;
    logic [DW-1:0] data;
  } ser_wr_t;

  typedef struct packed {
    logic [PW-1:0] start;
    logic          pol;
    logic [PW-1:0] len;
    logic [PW-1:0] last_len;
    logic          last_en;
    logic [PW-1:0] reps;
  } grp_cfg_t;

  typedef struct packed {
    gw_state_t     st;
    logic [PW-1:0] rep;
    logic [PW-1:0] rel;
    logic          wave;
  } gw_reg_t;

  typedef struct packed {
    logic                    sck_q;
    logic                    load_q;
    logic [5:0]              cnt;
    logic [SER_BITS-1:0]     sh;
    ser_wr_t                 wr;
  } ser_reg_t;

  typedef struct packed {
    logic [DW-1:0]            seq;
    logic [DW-1:0]            mode;
    logic [NREG-1:0][DW-1:0]  grp;
    logic [NPW-1:0][DW-1:0]   pat;
    logic [PW-1:0]            pix;
    logic [1:0]               phase;
    logic [NOUT-1:0]          vout;
    logic                     alt;
    logic                     merge;
    logic [SEG_W-1:0]         seg;
  } top_reg_t;
endpackage

// ==== verilog/serial_reg_port.sv ====
// Three-wire serial write port producing register write strobes
module serial_reg_port
  (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              ser_load_n,
  input  wire logic              ser_clk,
  input  wire logic              ser_data,
  output vcomb_pkg::ser_wr_t     wr
  );
  vcomb_pkg::ser_reg_t r_r;
  vcomb_pkg::ser_reg_t r_nxt;

  always_comb
  begin
    r_nxt = r_r;
    r_nxt.sck_q = ser_clk;
    r_nxt.load_q = ser_load_n;
    r_nxt.wr.wr = 1'b0;
    // Shift in on each rising serial clock, LSB first
    if (!ser_load_n && ser_clk && !r_r.sck_q)
    begin
      r_nxt.sh = {ser_data, r_r.sh[vcomb_pkg::SER_BITS-1:1]};
      if (r_r.cnt != vcomb_pkg::SER_LEN)
        r_nxt.cnt = r_r.cnt + vcomb_pkg::SER_ONE;
    end
    // Frame end: only a frame of full length or longer writes
    if (ser_load_n && !r_r.load_q)
    begin
      r_nxt.wr.wr = (r_r.cnt == vcomb_pkg::SER_LEN);
      r_nxt.wr.addr = r_r.sh[vcomb_pkg::ADR_W-1:0];
      r_nxt.wr.data = r_r.sh[vcomb_pkg::SER_BITS-1:vcomb_pkg::ADR_W];
      r_nxt.cnt = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      r_r <= '0;
      r_r.load_q <= 1'b1;
    end
    else
      r_r <= r_nxt;
  end

  assign wr = r_r.wr;
endmodule // serial_reg_port

// ==== verilog/group_wave.sv ====
// One vertical pattern group engine: start, repeats, toggles
module group_wave
  (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  line_start,
  input  wire logic [12:0]           pix,
  input  wire logic                  hold,
  input  vcomb_pkg::grp_cfg_t        cfg,
  input  vcomb_pkg::tog_pos_t        tog_pos,
  input  vcomb_pkg::tog_en_t         tog_en,
  output logic                       wave,
  output logic [12:0]                rep
  );
  vcomb_pkg::gw_reg_t r_r;
  vcomb_pkg::gw_reg_t r_nxt;
  logic [12:0]                cur_len;
  logic                       last_rep;
  logic [vcomb_pkg::NSLT-1:0] hit;

  assign last_rep = (r_r.rep == cfg.reps - vcomb_pkg::ONE13);
  assign cur_len  = (cfg.last_en && last_rep) ? cfg.last_len : cfg.len; // RL17

  for (genvar k = 0; k < vcomb_pkg::NSLT; k++)
  begin : g_hit
    assign hit[k] = tog_en[k] && (tog_pos[k] <= r_r.rel);
  end

  always_comb
  begin
    r_nxt = r_r;
    r_nxt.wave = (r_r.st == vcomb_pkg::GW_RUN) ? cfg.pol ^ (^hit) : cfg.pol;
    case (r_r.st)
      vcomb_pkg::GW_IDLE: ;
      vcomb_pkg::GW_WAIT:
        if (pix == cfg.start)
          r_nxt.st = (cfg.reps == '0) ? vcomb_pkg::GW_IDLE
                                      : vcomb_pkg::GW_RUN;
      vcomb_pkg::GW_RUN:
        if (!hold)
        begin
          if (r_r.rel == cur_len - vcomb_pkg::ONE13)
          begin
            r_nxt.rel = '0;
            r_nxt.rep = r_r.rep + vcomb_pkg::ONE13; // RL23
            if (last_rep)
              r_nxt.st = vcomb_pkg::GW_IDLE;
          end
          else
            r_nxt.rel = r_r.rel + vcomb_pkg::ONE13;
        end
      default: r_nxt.st = vcomb_pkg::GW_IDLE;
    endcase
    if (line_start)
    begin
      r_nxt.st = vcomb_pkg::GW_WAIT;
      r_nxt.rep = '0;
      r_nxt.rel = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  assign wave = r_r.wave;
  assign rep  = r_r.rep;

  last_len_a: assert property (@(posedge clk) disable iff (sys_rst) // RL17
    (r_r.st == vcomb_pkg::GW_RUN && !hold && !line_start && cfg.last_en
     && last_rep && r_r.rel == cfg.last_len - vcomb_pkg::ONE13)
    |=> r_r.st == vcomb_pkg::GW_IDLE)
    else $error("final repetition length not applied");
endmodule // group_wave

// ==== verilog/ccd_vertical_pattern_combiner.sv ====
// Vertical pattern combining: group routing, merge and alternation
module ccd_vertical_pattern_combiner
  (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        ser_load_n,
  input  wire logic                        ser_clk,
  input  wire logic                        ser_data,
  input  wire logic                        line_start,
  input  wire logic                        line_odd,
  output logic [vcomb_pkg::NOUT-1:0]       vertical_out,
  output logic                             alt_mode_active,
  output logic                             merge_active,
  output logic [vcomb_pkg::SEG_W-1:0]      segment_index
  );
  vcomb_pkg::top_reg_t  r_r;
  vcomb_pkg::top_reg_t  r_nxt;
  vcomb_pkg::ser_wr_t   wr;
  vcomb_pkg::grp_cfg_t  [vcomb_pkg::NGRP-1:0] cfg;
  vcomb_pkg::tog_pos_t  [vcomb_pkg::NGRP-1:0] spos;
  vcomb_pkg::tog_en_t   [vcomb_pkg::NGRP-1:0] sen;
  logic [vcomb_pkg::NGRP-1:0][vcomb_pkg::NTG-1:0][12:0] gpos;
  logic [vcomb_pkg::NGRP-1:0][vcomb_pkg::NTG-1:0]       gen;
  logic [vcomb_pkg::NGRP-1:0]                           wave;
  logic [vcomb_pkg::NGRP-1:0][12:0]                     grep;
  logic [vcomb_pkg::NHOLD-1:0]                          in_hold;
  logic [vcomb_pkg::SEL_W-1:0]                          sel0;
  logic [vcomb_pkg::SEL_W-1:0]                          sel1;
  logic [vcomb_pkg::SEG_W-1:0]                          seg;
  logic [vcomb_pkg::CHO_W-1:0]                          spc;
  logic [12:0]                                          a_reps;
  logic [12:0]                                          ins_pt;
  logic [1:0]                                           a_ph;
  logic [1:0]                                           ph_last;
  logic [1:0]                                           code;
  logic [1:0]                                           src;
  logic                                                 alt_on;
  logic                                                 map_on;
  logic                                                 sel_on;
  logic                                                 merge_on;
  logic                                                 ins_hit;
  logic                                                 hold;

  // ------------------------------------------------------------
  // Register write port
  // ------------------------------------------------------------
  serial_reg_port u_ser
    (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .ser_load_n (ser_load_n),
    .ser_clk    (ser_clk),
    .ser_data   (ser_data),
    .wr         (wr)
    );

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  assign alt_on   = r_r.mode[vcomb_pkg::B_ALT]; // RL2
  assign map_on   = r_r.mode[vcomb_pkg::B_MAP];
  assign sel_on   = alt_on && map_on; // RL3 RL8
  assign merge_on = (r_r.seq[vcomb_pkg::F_MERGE +: 4]
                     == vcomb_pkg::MERGE_ON); // RL14
  assign spc      = r_r.mode[vcomb_pkg::F_SPC +: vcomb_pkg::CHO_W];
  assign seg      = grep[0][vcomb_pkg::SEG_W-1:0];

  // Select words live in the hold/continue words: 12:0 and 17:13
  assign sel0 = line_odd // RL6 RL7
    ? r_r.grp[vcomb_pkg::I_HOLD0+2][vcomb_pkg::SEL_W-1:0]
    : r_r.grp[vcomb_pkg::I_HOLD0][vcomb_pkg::SEL_W-1:0]; // RL4
  assign sel1 = line_odd
    ? r_r.grp[vcomb_pkg::I_HOLD0+3][vcomb_pkg::SEL_W-1:0]
    : r_r.grp[vcomb_pkg::I_HOLD0+1][vcomb_pkg::SEL_W-1:0];

  // Insertion point is group B's count for this line
  assign ins_pt = line_odd
    ? r_r.grp[vcomb_pkg::I_STRIDE+vcomb_pkg::I_REP][12:0]
    : r_r.grp[vcomb_pkg::I_STRIDE+vcomb_pkg::I_REP][vcomb_pkg::F_HI +: 13];
  assign ins_hit = (grep[0] == ins_pt);

  // ------------------------------------------------------------
  // Hold areas, disabled while alternation is enabled, with or without map
  // ------------------------------------------------------------
  for (genvar k = 0; k < vcomb_pkg::NHOLD; k++)
  begin : g_hold
    assign in_hold[k] = r_r.seq[vcomb_pkg::F_HOLD+k]
      && r_r.pix >= r_r.grp[vcomb_pkg::I_HOLD0+k][12:0]
      && r_r.pix < r_r.grp[vcomb_pkg::I_HOLD0+k][vcomb_pkg::F_HI +: 13];
  end
  assign hold = !alt_on && (|in_hold); // RL8

  // ------------------------------------------------------------
  // Per-group configuration and engines
  // ------------------------------------------------------------
  for (genvar g = 0; g < vcomb_pkg::NGRP; g++)
  begin : g_grp
    localparam int B = g * vcomb_pkg::I_STRIDE;
    logic [vcomb_pkg::PAT_AW-1:0] pw;
    logic [vcomb_pkg::PAT_AW-1:0] pw2;

    assign pw  = {r_r.grp[B+vcomb_pkg::I_CHO][vcomb_pkg::CHO_W-1:0], 1'b0};
    assign pw2 = {r_r.grp[B+vcomb_pkg::I_CHO][vcomb_pkg::CHO_W-1:0], 1'b1};
    assign gpos[g][0] = r_r.pat[pw][12:0];
    assign gpos[g][1] = r_r.pat[pw][vcomb_pkg::F_HI +: 13];
    assign gpos[g][2] = r_r.pat[pw2][12:0];
    assign gpos[g][3] = r_r.pat[pw2][vcomb_pkg::F_HI +: 13];
    assign gpos[g][4] = r_r.grp[B+vcomb_pkg::I_CHO][vcomb_pkg::F_TOG5 +: 13];
    assign gen[g] = {r_r.seq[vcomb_pkg::F_FIFTH+g],
                     {vcomb_pkg::TG4{1'b1}}}; // RL1 RL24

    assign cfg[g].start    = r_r.grp[B+vcomb_pkg::I_START][12:0];
    assign cfg[g].pol      = r_r.grp[B+vcomb_pkg::I_START][vcomb_pkg::B_POL];
    assign cfg[g].len      = r_r.grp[B+vcomb_pkg::I_LEN][12:0];
    assign cfg[g].last_len = r_r.grp[B+vcomb_pkg::I_LEN][vcomb_pkg::F_HI +: 13];
    assign cfg[g].last_en  = r_r.seq[vcomb_pkg::F_FINAL+g]; // RL17
    if (g == 0)
    begin : g_a
      assign cfg[g].reps = a_reps;
    end
    else
    begin : g_bcd
      assign cfg[g].reps = line_odd // RL19
        ? r_r.grp[B+vcomb_pkg::I_REP][12:0]
        : r_r.grp[B+vcomb_pkg::I_REP][vcomb_pkg::F_HI +: 13];
    end

    group_wave u_wave
      (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .line_start (line_start),
      .pix        (r_r.pix),
      .hold       (hold),
      .cfg        (cfg[g]),
      .tog_pos    (spos[g]),
      .tog_en     (sen[g]),
      .wave       (wave[g]),
      .rep        (grep[g])
      );
  end

  // ------------------------------------------------------------
  // Group A sourcing: counts, segment codes, insertion, merge
  // ------------------------------------------------------------
  always_comb
  begin
    a_ph = (r_r.seq[vcomb_pkg::F_LINES +: 2] == '0)
           ? {1'b0, !line_odd} : r_r.phase; // RL19
    case (r_r.seq[vcomb_pkg::F_LINES +: 2])
      2'h0:    ph_last = vcomb_pkg::PH_LAST2;
      2'h1:    ph_last = vcomb_pkg::PH_LAST3;
      default: ph_last = vcomb_pkg::PH_LAST4; // RL20
    endcase
    case (a_ph)
      2'h0:    a_reps = r_r.grp[vcomb_pkg::I_REP][12:0];
      2'h1:    a_reps = r_r.grp[vcomb_pkg::I_REP][vcomb_pkg::F_HI +: 13];
      2'h2:    a_reps = r_r.grp[vcomb_pkg::I_AREP34][12:0]; // RL20
      default: a_reps = r_r.grp[vcomb_pkg::I_AREP34][vcomb_pkg::F_HI +: 13];
    endcase
    if (sel_on)
      a_reps = r_r.grp[vcomb_pkg::I_REP][12:0]; // RL9
    code = (grep[0] < vcomb_pkg::SEL_W) ? {sel0[seg], sel1[seg]}
                                         : vcomb_pkg::G_A; // RL5 RL23
    if (sel_on)
      src = code;
    else if (ins_hit && spc[0]) // RL11
      src = vcomb_pkg::G_B;
    else if (ins_hit && spc[1])
      src = vcomb_pkg::G_C;
    else if (ins_hit && spc[2])
      src = vcomb_pkg::G_D;
    else
      src = vcomb_pkg::G_A;
    spos = '0;
    sen = '0;
    for (int g = 1; g < vcomb_pkg::NGRP; g++)
    begin
      spos[g][vcomb_pkg::NTG-1:0] = gpos[g];
      sen[g][vcomb_pkg::NTG-1:0] = gen[g];
    end
    if (merge_on && !alt_on)
    begin
      for (int g = 0; g < vcomb_pkg::NGRP; g++)
      begin
        spos[0][g*vcomb_pkg::TG4 +: vcomb_pkg::TG4]
          = gpos[g][vcomb_pkg::TG4-1:0]; // RL14
        sen[0][g*vcomb_pkg::TG4 +: vcomb_pkg::TG4] = '1;
      end
      spos[0][vcomb_pkg::NSLT-1] = gpos[0][vcomb_pkg::NTG-1];
      sen[0][vcomb_pkg::NSLT-1] = gen[0][vcomb_pkg::NTG-1];
    end
    else
    begin
      spos[0][vcomb_pkg::NTG-1:0] = gpos[src];
      sen[0][vcomb_pkg::NTG-1:0] = gen[src];
    end
  end

  // ------------------------------------------------------------
  // State update
  // ------------------------------------------------------------
  always_comb
  begin
    logic [1:0] gs;
    gs = vcomb_pkg::G_A;
    r_nxt = r_r;
    if (wr.wr)
    begin
      if (wr.addr == vcomb_pkg::A_SEQ)
        r_nxt.seq = wr.data;
      else if (wr.addr == vcomb_pkg::A_MODE)
        r_nxt.mode = wr.data; // RL2
      else if (wr.addr >= vcomb_pkg::A_GRP0 && wr.addr <= vcomb_pkg::A_GRPN)
        r_nxt.grp[wr.addr - vcomb_pkg::A_GRP0] = wr.data;
      else if (wr.addr >= vcomb_pkg::A_PAT0 && wr.addr <= vcomb_pkg::A_PATN)
        r_nxt.pat[wr.addr[vcomb_pkg::PAT_AW-1:0]] = wr.data;
    end
    r_nxt.pix = line_start ? '0 : r_r.pix + vcomb_pkg::ONE13;
    if (line_start)
      r_nxt.phase = (r_r.phase >= ph_last) ? '0
                    : r_r.phase + vcomb_pkg::PH_STEP; // RL20
    for (int o = 0; o < vcomb_pkg::NOUT; o++)
    begin
      gs = r_r.grp[vcomb_pkg::I_GSEL0 + o / vcomb_pkg::GSEL_PER]
                  [(o % vcomb_pkg::GSEL_PER) * 2 +: 2];
      r_nxt.vout[o] = (merge_on || alt_on) ? wave[0] : wave[gs]; // RL12 RL15
    end
    r_nxt.alt = sel_on;
    r_nxt.merge = merge_on && !alt_on;
    r_nxt.seg = seg;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  assign vertical_out    = r_r.vout;
  assign alt_mode_active = r_r.alt;
  assign merge_active    = r_r.merge;
  assign segment_index   = r_r.seg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence alt_write_s;
    wr.wr && wr.addr == vcomb_pkg::A_MODE && wr.data[vcomb_pkg::B_ALT];
  endsequence
  sequence alt_seen_s;
    alt_on ##1 (alt_on || wr.wr);
  endsequence

  alt_enable_a: assert property (alt_write_s |=> alt_seen_s) // RL2
    else $error("alternation enable not taken");
  merge_route_a: assert property ((merge_on && !alt_on) // RL15
    |=> vertical_out == {vcomb_pkg::NOUT{$past(wave[0])}})
    else $error("merged outputs not following group A");
  group_route_a: assert property ((!merge_on && !alt_on // RL12
    && r_r.grp[vcomb_pkg::I_GSEL0][1:0] == vcomb_pkg::G_B)
    |=> vertical_out[0] == $past(wave[1]))
    else $error("output not following its group");
  seg_code_a: assert property (sel_on && grep[0] == 13'h0000 // RL5
    |-> src == (line_odd
      ? {r_r.grp[vcomb_pkg::I_HOLD0+2][0], r_r.grp[vcomb_pkg::I_HOLD0+3][0]}
      : {r_r.grp[vcomb_pkg::I_HOLD0][0], r_r.grp[vcomb_pkg::I_HOLD0+1][0]}))
    else $error("segment code mismatch"); // RL6 RL7
  seg_reps_a: assert property (sel_on // RL9
    |-> cfg[0].reps == r_r.grp[vcomb_pkg::I_REP][12:0])
    else $error("segment count not from first count");
  seg_restart_a: assert property (line_start |=> grep[0] == 13'h0000) // RL23
    else $error("segment index not restarted");
  insert_prio_a: assert property ((!sel_on && ins_hit && spc[0]) // RL11
    |-> src == vcomb_pkg::G_B)
    else $error("insertion priority wrong");
  select_gate_a: assert property ((!sel_on && !ins_hit) // RL8
    |-> src == vcomb_pkg::G_A)
    else $error("select used outside alternation");
  fifth_gate_a: assert property (!r_r.seq[vcomb_pkg::F_FIFTH+3] // RL1
    |-> !gen[3][vcomb_pkg::NTG-1])
    else $error("fifth toggle active while disabled");
  line_reps_a: assert property (line_odd // RL19
    |-> cfg[1].reps == r_r.grp[vcomb_pkg::I_STRIDE+vcomb_pkg::I_REP][12:0])
    else $error("odd line count not used");
endmodule // ccd_vertical_pattern_combiner

// ==== bench/vdrive_model.sv ====
// Vertical driver and sensor model: counts output pulses per line
module vdrive_model
  (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic                          line_start,
  input  wire logic [vcomb_pkg::NOUT-1:0]    vertical_out,
  output logic [vcomb_pkg::NOUT-1:0][7:0]    rises
  );
  timeunit 1ns;
  timeprecision 1ns;

  logic [vcomb_pkg::NOUT-1:0] prev_r;

  // ----------------------------------------
  // Rising edges seen since the line began
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    prev_r <= vertical_out;
    if (sys_rst || line_start)
      rises <= '0;
    else
      for (int i = 0; i < vcomb_pkg::NOUT; i++)
        if (vertical_out[i] && !prev_r[i])
          rises[i] <= rises[i] + 8'h01;
  end
endmodule // vdrive_model

// ==== bench/ccd_vertical_pattern_combiner_bench.sv ====
// Self-checking bench for the vertical pattern combiner
module ccd_vertical_pattern_combiner_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic                          clk;
  logic                          sys_rst;
  logic                          ser_load_n;
  logic                          ser_clk;
  logic                          ser_data;
  logic                          line_start;
  logic                          line_odd;
  logic [vcomb_pkg::NOUT-1:0]    vertical_out;
  logic                          alt_mode_active;
  logic                          merge_active;
  logic [vcomb_pkg::SEG_W-1:0]   segment_index;
  logic [vcomb_pkg::NOUT-1:0][7:0] rises;
  int                            bad_count;
  int                            cmp_count;

  ccd_vertical_pattern_combiner u_dut
    (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .ser_load_n      (ser_load_n),
    .ser_clk         (ser_clk),
    .ser_data        (ser_data),
    .line_start      (line_start),
    .line_odd        (line_odd),
    .vertical_out    (vertical_out),
    .alt_mode_active (alt_mode_active),
    .merge_active    (merge_active),
    .segment_index   (segment_index)
    );

  vdrive_model u_drv
    (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .line_start   (line_start),
    .vertical_out (vertical_out),
    .rises        (rises)
    );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [23:0] e,
                     input logic [23:0] s);
    cmp_count++;
    if (s !== e)
    begin
      $display("[ERR] %s expected %0h seen %0h", n, e, s);
      bad_count++;
    end
  endtask

  function automatic logic [23:0] r(input int i);
    return {16'h0000, rises[i]};
  endfunction

  // Serial frame: address then data, LSB first
  task automatic wr(input logic [7:0] a, input logic [25:0] d);
    logic [33:0] f;
    f = {d, a};
    ser_load_n <= 1'b0;
    for (int i = 0; i < 34; i++)
    begin
      @(posedge clk);
      ser_clk  <= 1'b0;
      ser_data <= f[i];
      @(posedge clk);
      ser_clk <= 1'b1;
    end
    @(posedge clk);
    ser_load_n <= 1'b1;
    ser_clk    <= 1'b0;
    repeat (5) @(posedge clk);
  endtask

  task automatic line(input logic odd);
    @(posedge clk);
    line_odd   <= odd;
    line_start <= 1'b1;
    @(posedge clk);
    line_start <= 1'b0;
    repeat (90) @(posedge clk);
  endtask

  task conclude;
    if (bad_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, watchdog, tests
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    #100000;
    bad_count++;
    conclude();
  end

  initial
  begin
    bad_count  = 0;
    cmp_count  = 0;
    sys_rst    = 1'b1;
    ser_load_n = 1'b1;
    ser_clk    = 1'b0;
    ser_data   = 1'b0;
    line_start = 1'b0;
    line_odd   = 1'b0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("vout_rst", 24'h0, vertical_out);
    chk("alt_rst", 24'h0, {23'h0, alt_mode_active});
    wr(8'h40, {13'h0005, 13'h0002});
    wr(8'h42, {13'h0002, 13'h0001});
    wr(8'h43, {13'h0005, 13'h0004});
    wr(8'h46, {13'h0009, 13'h0007});
    for (int g = 0; g < 4; g++)
    begin
      wr(8'(1 + 4 * g), 26'h0000002);
      wr(8'(2 + 4 * g), {13'h000C, 13'h000C});
      wr(8'(3 + 4 * g), {13'h0001, 13'h0001});
      wr(8'(4 + 4 * g), 26'(g));
    end
    wr(8'h16, 26'h0);
    wr(8'h17, 26'h0);
    line(1'b1);
    chk("a_out0", 24'h1, r(0));
    chk("a_out23", 24'h1, r(23));
    wr(8'h16, 26'h0000001);
    wr(8'h07, {13'h0004, 13'h0002});
    line(1'b1);
    chk("b_odd", 24'h4, r(0));
    chk("a_out1", 24'h1, r(1));
    line(1'b0);
    chk("b_even", 24'h8, r(0));
    wr(8'h16, 26'h0);
    wr(8'h12, 26'h0000002);
    wr(8'h13, 26'h0000003);
    wr(8'h03, {13'h0003, 13'h0003});
    wr(8'h07, {13'h0004, 13'h0001});
    wr(8'h20, 26'h0000001);
    line(1'b1);
    chk("insert_b", 24'h4, r(0));
    wr(8'h20, 26'h0002000);
    chk("alt_nomap", 24'h0, {23'h0, alt_mode_active});
    wr(8'h20, 26'h0006000);
    chk("alt_on", 24'h1, {23'h0, alt_mode_active});
    line(1'b0);
    chk("alt_even", 24'h4, r(0));
    chk("seg_even", 24'h3, {19'h0, segment_index});
    line(1'b1);
    chk("alt_odd", 24'h3, r(0));
    wr(8'h00, 26'h00F0400);
    chk("merge_alt", 24'h0, {23'h0, merge_active});
    wr(8'h20, 26'h0);
    chk("merge_on", 24'h1, {23'h0, merge_active});
    wr(8'h0C, 26'h0000001);
    wr(8'h10, 26'h0000001);
    wr(8'h03, {13'h0001, 13'h0001});
    wr(8'h05, 26'h0000009);
    wr(8'h40, {13'h0008, 13'h0007});
    line(1'b1);
    chk("merge_out", 24'h3, r(0));
    conclude();
  end
endmodule // ccd_vertical_pattern_combiner_bench
